// ---- include/ipl_pkg.sv ----
// Constants and types for the ingress port learning and policing configuration block
package ipl_pkg;
  localparam int unsigned IPL_ADDR_W = 4;
  localparam logic [IPL_ADDR_W-1:0] IPL_LEARN_CFG_OFS = 4'h0;
  localparam logic [IPL_ADDR_W-1:0] IPL_INGRESS_PORT_POLICING_CONFIG_OFS = 4'h4;
  localparam logic [IPL_ADDR_W-1:0] IPL_FRAME_CNT_OFS = 4'h8;
  localparam logic [IPL_ADDR_W-1:0] IPL_LAST_RES_OFS = 4'hc;
  localparam logic [1:0] IPL_HTRANS_NONSEQ = 2'h2;
  localparam int unsigned IPL_NUM_POL = 3;
  localparam int unsigned IPL_POL_PORT = 0;
  localparam int unsigned IPL_POL_CLASS = 1;
  localparam int unsigned IPL_POL_CONTENT = 2;
  localparam int unsigned IPL_CLASS_W = 3;
  localparam int unsigned IPL_PORT_W = 4;
  localparam int unsigned IPL_SVC_W = 10;
  localparam int unsigned IPL_QUEUE_W = 3;
  localparam int unsigned IPL_POL_IDX_W = 8;
  localparam logic [IPL_POL_IDX_W-1:0] IPL_CLASS_POL_BASE = 8'h20;

  // Field order gives the bit positions, most significant first
  typedef struct packed {
    logic locked_move_copy_to_cpu;
    logic learn_frame_discard;
    logic learn_frame_copy_to_cpu;
    logic learn_automatic;
    logic learning_enable;
    logic receive_forward_enable;
    logic [IPL_PORT_W-1:0] logical_port_number;
    logic backbone_domain_select;
    logic label_switch_router_mode;
  } ipl_learn_cfg_s;

  typedef struct packed {
    logic port_policer_enable;
    logic [(1<<IPL_CLASS_W)-1:0] class_policer_mask;
    logic [IPL_NUM_POL*IPL_NUM_POL-1:0] policer_ordering_matrix;
  } ipl_ingress_port_policing_config_s;

  localparam ipl_learn_cfg_s IPL_LEARN_CFG_RST = 12'h1c0;
  localparam ipl_ingress_port_policing_config_s IPL_INGRESS_PORT_POLICING_CONFIG_RST = 18'h001ff;

  typedef enum logic [1:0] {
    IPL_PH_IDLE = 2'h0,
    IPL_PH_READ = 2'h1,
    IPL_PH_WRITE = 2'h3
  } ipl_phase_e;

  typedef struct packed {
    logic valid;
    logic [IPL_PORT_W-1:0] phys_port;
    logic [IPL_CLASS_W-1:0] qos_class;
    logic [IPL_SVC_W-1:0] service_index;
    logic service_policer_select;
    logic learn_frame;
    logic locked_move;
    logic content_aware_hit;
    logic [IPL_NUM_POL-1:0] pol_open;
  } ipl_frame_s;

  typedef struct packed {
    logic valid;
    logic table_lookup;
    logic fwd_result_zero;
    logic hw_learn;
    logic learn_copy_cpu;
    logic learn_fwd_discard;
    logic locked_copy_cpu;
    logic [IPL_QUEUE_W-1:0] learn_queue;
    logic [IPL_QUEUE_W-1:0] locked_queue;
    logic [IPL_PORT_W-1:0] logical_port;
    logic backbone_domain;
    logic label_switch;
    logic port_pol_use;
    logic [IPL_POL_IDX_W-1:0] port_pol_idx;
    logic class_pol_use;
    logic [IPL_POL_IDX_W-1:0] class_pol_idx;
    logic [IPL_NUM_POL-1:0] pol_update;
  } ipl_result_s;

  typedef struct packed {
    ipl_phase_e phase;
    logic [IPL_ADDR_W-1:0] addr;
    logic [31:0] rdata;
    ipl_learn_cfg_s learn;
    ipl_ingress_port_policing_config_s pol;
    logic [31:0] frame_cnt;
    ipl_result_s res;
  } ipl_state_s;
endpackage

// ---- hw/ipl_port_cfg.sv ----
// Ingress port learning, lookup and policing configuration with AHB-Lite registers
//
// Implementation choices: the AHB-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
module ipl_port_cfg
  import ipl_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic [ipl_pkg::IPL_QUEUE_W-1:0] cpu_learn_queue,
  input wire logic [ipl_pkg::IPL_QUEUE_W-1:0] cpu_locked_move_queue,
  input wire ipl_pkg::ipl_frame_s frame_in,
  output ipl_pkg::ipl_result_s result
);
  import ipl_pkg::*;

  ipl_state_s st_q;
  ipl_state_s st_d;

  // Policer m is updated only if every policer n selected for it is open
  function automatic logic [IPL_NUM_POL-1:0] pol_gate(
    input logic [IPL_NUM_POL*IPL_NUM_POL-1:0] order,
    input logic [IPL_NUM_POL-1:0] open,
    input logic [IPL_NUM_POL-1:0] active
  );
    logic [IPL_NUM_POL-1:0] upd;
    upd = '0;
    for (int m = 0; m < IPL_NUM_POL; m++)
    begin
      upd[m] = active[m];
      for (int n = 0; n < IPL_NUM_POL; n++)
      begin
        if (order[n + IPL_NUM_POL*m] && !open[n])
        begin
          upd[m] = 1'b0;
        end
      end
    end
    return upd;
  endfunction

  function automatic logic [31:0] rd_value(
    input logic [IPL_ADDR_W-1:0] addr,
    input ipl_state_s s
  );
    logic [31:0] v;
    v = 32'h0000_0000;
    case (addr)
      IPL_LEARN_CFG_OFS: v[$bits(ipl_learn_cfg_s)-1:0] = s.learn;
      IPL_INGRESS_PORT_POLICING_CONFIG_OFS: v[$bits(ipl_ingress_port_policing_config_s)-1:0] = s.pol;
      IPL_FRAME_CNT_OFS: v = s.frame_cnt;
      IPL_LAST_RES_OFS:
      begin
        v[IPL_NUM_POL-1:0] = s.res.pol_update;
        v[IPL_NUM_POL] = s.res.hw_learn;
        v[IPL_NUM_POL+1] = s.res.learn_copy_cpu;
        v[IPL_NUM_POL+2] = s.res.learn_fwd_discard;
        v[IPL_NUM_POL+3] = s.res.locked_copy_cpu;
        v[IPL_NUM_POL+4] = s.res.table_lookup;
      end
      default: v = 32'h0000_0000;
    endcase
    return v;
  endfunction

  logic learn_on;
  logic learn_hit;
  logic locked_hit;
  logic svc_pol_active;
  logic class_ok;
  logic class_use;
  logic [IPL_NUM_POL-1:0] pol_active;
  logic [IPL_NUM_POL-1:0] pol_eff_open;

  always_comb
  begin
    st_d = st_q;
    // Writes land in the data phase, so a read right behind sees them
    if (st_q.phase == IPL_PH_WRITE)
    begin
      case (st_q.addr)
        IPL_LEARN_CFG_OFS: st_d.learn = hwdata[$bits(ipl_learn_cfg_s)-1:0];
        IPL_INGRESS_PORT_POLICING_CONFIG_OFS: st_d.pol = hwdata[$bits(ipl_ingress_port_policing_config_s)-1:0];
        IPL_FRAME_CNT_OFS: st_d.frame_cnt = 32'h0000_0000;
        default: st_d.frame_cnt = st_d.frame_cnt;
      endcase
    end

    // Learning decisions
    // Enable gates learning
    learn_on = st_d.learn.learning_enable;
    learn_hit = learn_on && frame_in.learn_frame;
    locked_hit = learn_on && frame_in.locked_move;

    svc_pol_active = (frame_in.service_index != '0) && frame_in.service_policer_select;
    class_ok = !svc_pol_active;
    class_use = st_d.pol.class_policer_mask[frame_in.qos_class] && class_ok;

    pol_active[IPL_POL_PORT] = st_d.pol.port_policer_enable;
    pol_active[IPL_POL_CLASS] = class_use || svc_pol_active;
    pol_active[IPL_POL_CONTENT] = frame_in.content_aware_hit;
    // A policer not in use never holds a frame back
    pol_eff_open = frame_in.pol_open | ~pol_active;

    st_d.res.valid = frame_in.valid;
    if (frame_in.valid)
    begin
      // A frame in the same cycle as a clear is counted after it, so the count becomes 1
      st_d.frame_cnt = st_d.frame_cnt + 32'h0000_0001;
      st_d.res.table_lookup = st_d.learn.receive_forward_enable;
      st_d.res.fwd_result_zero = !st_d.learn.receive_forward_enable;
      st_d.res.hw_learn = learn_hit && st_d.learn.learn_automatic;
      st_d.res.learn_copy_cpu = learn_hit && st_d.learn.learn_frame_copy_to_cpu;
      st_d.res.learn_queue = cpu_learn_queue;
      st_d.res.learn_fwd_discard = learn_hit && st_d.learn.learn_frame_discard;
      st_d.res.locked_copy_cpu = locked_hit && st_d.learn.locked_move_copy_to_cpu;
      st_d.res.locked_queue = cpu_locked_move_queue;
      st_d.res.logical_port = st_d.learn.logical_port_number;
      st_d.res.backbone_domain = st_d.learn.backbone_domain_select;
      st_d.res.label_switch = st_d.learn.label_switch_router_mode;
      st_d.res.port_pol_use = st_d.pol.port_policer_enable;
      st_d.res.port_pol_idx = {{(IPL_POL_IDX_W-IPL_PORT_W){1'b0}}, frame_in.phys_port};
      st_d.res.class_pol_use = class_use;
      st_d.res.class_pol_idx = IPL_CLASS_POL_BASE
        + {1'b0, frame_in.phys_port, frame_in.qos_class};
      st_d.res.pol_update = pol_gate(st_d.pol.policer_ordering_matrix, pol_eff_open,
        pol_active);
    end

    // Address phase; single slave, so the bus is always ready
    st_d.phase = IPL_PH_IDLE;
    if (hsel && hready && (htrans == IPL_HTRANS_NONSEQ))
    begin
      st_d.addr = haddr[IPL_ADDR_W-1:0];
      st_d.phase = hwrite ? IPL_PH_WRITE : IPL_PH_READ;
      if (!hwrite)
      begin
        st_d.rdata = rd_value(haddr[IPL_ADDR_W-1:0], st_d);
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st_q <= '0;
      st_q.phase <= IPL_PH_IDLE;
      st_q.learn <= IPL_LEARN_CFG_RST;
      st_q.pol <= IPL_INGRESS_PORT_POLICING_CONFIG_RST;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = st_q.rdata;
  assign result = st_q.res;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  a_learn_off_gate: assert property (
    frame_in.valid && !st_d.learn.learning_enable |=> !result.hw_learn
      && !result.learn_copy_cpu && !result.learn_fwd_discard && !result.locked_copy_cpu)
    else $error("learning action while learning disabled");

  a_auto_learn_set: assert property (
    frame_in.valid && frame_in.learn_frame && st_d.learn.learning_enable
      && st_d.learn.learn_automatic |=> result.valid && result.hw_learn)
    else $error("auto learn missing");

  a_learn_copy_queue: assert property (
    frame_in.valid && frame_in.learn_frame && st_d.learn.learning_enable
      && st_d.learn.learn_frame_copy_to_cpu
      |=> result.learn_copy_cpu && result.learn_queue == $past(cpu_learn_queue))
    else $error("learn copy wrong");

  a_learn_discard_set: assert property (
    frame_in.valid && frame_in.learn_frame && st_d.learn.learning_enable
      && st_d.learn.learn_frame_discard |=> result.learn_fwd_discard)
    else $error("learn discard missing");

  a_locked_copy_queue: assert property (
    frame_in.valid && frame_in.locked_move && st_d.learn.learning_enable
      && st_d.learn.locked_move_copy_to_cpu
      |=> result.locked_copy_cpu && result.locked_queue == $past(cpu_locked_move_queue))
    else $error("locked move copy wrong");

  a_lookup_off: assert property (
    frame_in.valid && !st_d.learn.receive_forward_enable
      |=> !result.table_lookup && result.fwd_result_zero)
    else $error("lookup not suppressed");

  a_port_ident: assert property (
    frame_in.valid |=> result.logical_port == $past(st_d.learn.logical_port_number)
      && result.backbone_domain == $past(st_d.learn.backbone_domain_select)
      && result.label_switch == $past(st_d.learn.label_switch_router_mode))
    else $error("port identity or mode mismatch");

  a_port_pol_idx: assert property (
    frame_in.valid && st_d.pol.port_policer_enable
      |=> result.port_pol_use && result.port_pol_idx == 8'(8'h00 + $past(frame_in.phys_port)))
    else $error("port policer index wrong");

  a_class_pol_idx: assert property (
    frame_in.valid |=> result.class_pol_idx
      == 8'(IPL_CLASS_POL_BASE + $past(frame_in.phys_port) * 8 + $past(frame_in.qos_class)))
    else $error("class policer index wrong");

  a_service_excl: assert property (
    frame_in.valid && frame_in.service_index != '0 && frame_in.service_policer_select
      |=> !result.class_pol_use)
    else $error("class policing with active service policer");

  a_order_block: assert property (
    frame_in.valid && st_d.pol.port_policer_enable && !frame_in.pol_open[IPL_POL_PORT]
      && (&st_d.pol.policer_ordering_matrix) |=> result.pol_update == 3'h0)
    else $error("policer updated with closed port policer");

  a_order_free: assert property (
    frame_in.valid && st_d.pol.policer_ordering_matrix == 9'h000
      && st_d.pol.port_policer_enable |=> result.pol_update[IPL_POL_PORT])
    else $error("ungated port policer not updated");

  a_order_reset: assert property (
    $rose(arst_n) |-> st_q.pol.policer_ordering_matrix == 9'h1ff)
    else $error("ordering reset value wrong");

  c_auto_learn: cover property (result.valid && result.hw_learn);
  c_learn_drop: cover property (result.valid && result.learn_fwd_discard
    && result.learn_copy_cpu);
  c_pol_blocked: cover property (result.valid && result.port_pol_use
    && !result.pol_update[IPL_POL_PORT]);
  c_pol_write: cover property (st_q.phase == IPL_PH_WRITE && st_q.addr == IPL_INGRESS_PORT_POLICING_CONFIG_OFS);
endmodule

// ---- dv/ipl_port_cfg_test.sv ----
// Self-checking bench for the ingress port learning and policing configuration block
`timescale 1ns/1ps
module ipl_port_cfg_test;
  import ipl_pkg::*;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic hready;
  logic hreadyout;
  logic [31:0] hrdata;
  logic hresp;
  logic [2:0] cpu_learn_queue = 3'h0;
  logic [2:0] cpu_locked_move_queue = 3'h0;
  ipl_frame_s frame_in = '0;
  ipl_result_s result;
  int err_count = 0;
  int checks = 0;

  always #5 clk = ~clk;
  // Single slave, so its ready closes the loop
  assign hready = hreadyout;

  ipl_port_cfg i_dut (.clk(clk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp), .cpu_learn_queue(cpu_learn_queue),
    .cpu_locked_move_queue(cpu_locked_move_queue), .frame_in(frame_in), .result(result));

  task automatic final_report();
    $display("checks %0d err_count %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("wrong value at %0d ns: got %h expected %h", $time, got, exp);
    end
  endtask

  // Bounded wait for the slave to accept or finish a phase
  task automatic wait_ready();
    int n;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (hready !== 1'b1 && n < 50);
    if (hready !== 1'b1)
    begin
      err_count++;
      final_report();
    end
  endtask

  task automatic bus(input logic w, input logic [3:0] ofs, input logic [31:0] wd,
    output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= {28'h0, ofs};
    hwrite <= w;
    hsize <= 3'h2;
    htrans <= IPL_HTRANS_NONSEQ;
    wait_ready();
    htrans <= 2'h0;
    hwdata <= wd;
    wait_ready();
    rd = hrdata;
    check(hresp, 1'b0);
  endtask

  task automatic wr(input logic [3:0] ofs, input logic [31:0] wd);
    logic [31:0] rd;
    bus(1'b1, ofs, wd, rd);
  endtask

  task automatic rdc(input logic [3:0] ofs, input logic [31:0] exp);
    logic [31:0] rd;
    bus(1'b0, ofs, 32'h0, rd);
    check(rd, exp);
  endtask

  task automatic reset_dut();
    arst_n <= 1'b0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
  endtask

  function automatic ipl_result_s model(ipl_learn_cfg_s l, ipl_ingress_port_policing_config_s p, ipl_frame_s f);
    ipl_result_s r;
    logic [2:0] act;
    logic [2:0] opn;
    r = '0;
    r.valid = 1'b1;
    r.table_lookup = l.receive_forward_enable;
    r.fwd_result_zero = !l.receive_forward_enable;
    r.hw_learn = l.learning_enable & l.learn_automatic & f.learn_frame;
    r.learn_copy_cpu = l.learning_enable & l.learn_frame_copy_to_cpu & f.learn_frame;
    r.learn_fwd_discard = l.learning_enable & l.learn_frame_discard & f.learn_frame;
    r.locked_copy_cpu = l.learning_enable & l.locked_move_copy_to_cpu & f.locked_move;
    r.learn_queue = cpu_learn_queue;
    r.locked_queue = cpu_locked_move_queue;
    r.logical_port = l.logical_port_number;
    r.backbone_domain = l.backbone_domain_select;
    r.label_switch = l.label_switch_router_mode;
    r.port_pol_use = p.port_policer_enable;
    r.port_pol_idx = {4'h0, f.phys_port};
    // class policing only without service policer
    r.class_pol_use = p.class_policer_mask[f.qos_class] &
      (f.service_index == '0 || !f.service_policer_select);
    // class Q on port P uses 32+P*8+Q
    r.class_pol_idx = 8'(32 + 8 * f.phys_port + f.qos_class);
    act = {f.content_aware_hit,
      r.class_pol_use | (f.service_index != '0 && f.service_policer_select),
      p.port_policer_enable};
    // Inactive policers never block the others
    opn = f.pol_open | ~act;
    for (int m = 0; m < 3; m++)
      r.pol_update[m] = act[m] & (&(opn | ~p.policer_ordering_matrix[3*m +: 3]));
    return r;
  endfunction

  // Indices matter only while their policer is in use
  function automatic ipl_result_s clean(ipl_result_s r, ipl_result_s e);
    if (!e.port_pol_use)
      r.port_pol_idx = '0;
    if (!e.class_pol_use)
      r.class_pol_idx = '0;
    return r;
  endfunction

  task automatic send(input ipl_frame_s f, input ipl_result_s e);
    frame_in <= f;
    @(posedge clk);
    frame_in.valid <= 1'b0;
    @(posedge clk);
    check(64'(clean(result, e)), 64'(clean(e, e)));
  endtask

  initial
  begin
    ipl_learn_cfg_s lc;
    ipl_ingress_port_policing_config_s pc;
    ipl_frame_s f;
    ipl_result_s e;
    reset_dut();
    rdc(IPL_LEARN_CFG_OFS, 32'h000001c0);
    rdc(IPL_INGRESS_PORT_POLICING_CONFIG_OFS, 32'h000001ff);
    rdc(IPL_FRAME_CNT_OFS, 32'h0);
    wr(IPL_LEARN_CFG_OFS, 32'hffffffff);
    rdc(IPL_LEARN_CFG_OFS, 32'h00000fff);
    wr(IPL_INGRESS_PORT_POLICING_CONFIG_OFS, 32'hffffffff);
    rdc(IPL_INGRESS_PORT_POLICING_CONFIG_OFS, 32'h0003ffff);
    reset_dut();
    rdc(IPL_LEARN_CFG_OFS, 32'h000001c0);
    rdc(IPL_INGRESS_PORT_POLICING_CONFIG_OFS, 32'h000001ff);
    for (int i = 0; i < 40; i++)
    begin
      lc = 12'(i * 421);
      lc.logical_port_number = 4'(i % 7);
      pc = (i < 4) ? 18'h3ffff : 18'(i * 40503);
      // Ungated ordering, so the port policer updates freely
      if (i % 8 == 5)
      begin
        pc.policer_ordering_matrix = 9'h000;
        pc.port_policer_enable = 1'b1;
      end
      cpu_learn_queue <= 3'(i);
      cpu_locked_move_queue <= 3'(i + 3);
      wr(IPL_LEARN_CFG_OFS, {20'h0, lc});
      wr(IPL_INGRESS_PORT_POLICING_CONFIG_OFS, {14'h0, pc});
      rdc(IPL_INGRESS_PORT_POLICING_CONFIG_OFS, {14'h0, pc});
      f = '0;
      f.valid = 1'b1;
      f.phys_port = 4'(i);
      f.qos_class = 3'(i >> 1);
      f.service_index = (i % 3 == 0) ? 10'h0 : 10'(i);
      f.service_policer_select = i[1];
      f.learn_frame = i[0];
      f.locked_move = i[2] | i[0];
      f.content_aware_hit = i[3] | i[0];
      f.pol_open = 3'(i * 5);
      e = model(lc, pc, f);
      send(f, e);
    end
    // Result valid stands one cycle only
    @(posedge clk);
    check(result.valid, 1'b0);
    rdc(IPL_FRAME_CNT_OFS, 32'd40);
    rdc(IPL_LAST_RES_OFS, {24'h0, e.table_lookup, e.locked_copy_cpu, e.learn_fwd_discard,
      e.learn_copy_cpu, e.hw_learn, e.pol_update});
    wr(IPL_FRAME_CNT_OFS, 32'h12345678);
    rdc(IPL_FRAME_CNT_OFS, 32'h0);
    final_report();
  end

  initial
  begin
    repeat (100000) @(posedge clk);
    err_count++;
    final_report();
  end
endmodule
